//--- hdl/ldpc_pkg.sv
// Constants shared by the LED display and program pin control block.
// Assumes a 125 MHz system clock and AHB-Lite access with 32-bit words.
package ldpc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_MHZ          = 125;  // System clock rate
	localparam int unsigned SETTLE_US        = 10;   // Program pin settle time
	localparam int unsigned SETTLE_CYC       = SETTLE_US * CLK_MHZ;
	localparam int unsigned DISPLAY_REQUEST_INPUT_HOLD_MS     = 4000; // Push button display time
	localparam int unsigned DISPLAY_REQUEST_INPUT_HOLD_CYC    = DISPLAY_REQUEST_INPUT_HOLD_MS * 1000 * CLK_MHZ;

	////////////////////////////////////////////////////////////////////////
	// Three level pin codes
	localparam logic [1:0]  LVL_LOW          = 2'h0; // Pulled down
	localparam logic [1:0]  LVL_FLOAT        = 2'h1; // Left open
	localparam logic [1:0]  LVL_HIGH         = 2'h2; // Pulled up

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL         = 8'h00; // Test override control
	localparam logic [7:0]  OFS_TEST         = 8'h04; // Commanded pin values
	localparam logic [7:0]  OFS_STATUS       = 8'h08; // Block state
	localparam logic [7:0]  OFS_PROG         = 8'h0C; // Latched program codes
	localparam logic [7:0]  OFS_NAC          = 8'h10; // Available charge
	localparam logic [7:0]  OFS_LMD          = 8'h14; // Learned capacity
	localparam logic [7:0]  OFS_EDV          = 8'h18; // End discharge levels

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int          CTRL_OVR_BIT     = 0;  // Host override enable
	localparam int          TEST_LED_COMMON_DRIVE_BIT    = 5;  // Commanded common drive
	localparam int          EDV_FINAL_LSB    = 16; // Final level field

	////////////////////////////////////////////////////////////////////////
	// Reset values and scaling
	localparam int          CHG_W            = 24; // Charge counter width
	localparam logic [23:0] PFC_STEP         = 24'h010000; // Full count step
	localparam logic [11:0] EDV_FIRST_RST    = 12'h400; // First level
	localparam logic [11:0] EDV_FINAL_RST    = 12'h3A0; // Final level
	localparam logic [15:0] OVLD_LO          = 16'h4000; // Overload, low
	localparam logic [15:0] OVLD_HI          = 16'h6000; // Overload, high
	localparam int          NUM_SEG          = 5;  // Display segments

	// Block states
	typedef enum logic [1:0] {
		ST_INIT,
		ST_SAMPLE,
		ST_RUN
	} ldpc_state_t;

endpackage

//--- hdl/ldpc_top.sv
// LED capacity display and shared program pin sampling, with AHB-Lite regs.
// Assumes three level pins arrive already coded and synchronous to sys_clk;
// the testbench resolves the open-drain and two-way pins from the enables.
//
// Behaviour
// - Common drive off while program pins sampled
// - Common drive high impedance when display off
// - Lit segment sinks the common drive current
// - Three-level program codes select all settings except the end-discharge thresholds
// - Display request high keeps display disabled
// - Floating request allows automatic display when charging
// - Falling display request turns display on
// - Integrate sense; positive charges, negative discharges
// - Five segments show available charge
// - Host commanded outputs override normal display
// - Battery voltage checked against end-discharge thresholds
// - Relative uses learned capacity, absolute programmed full
`timescale 1ns/1ps
`default_nettype none

module ldpc_top #(
	parameter int unsigned SETTLE_CYC    = ldpc_pkg::SETTLE_CYC,
	parameter int unsigned DISPLAY_REQUEST_INPUT_HOLD_CYC = ldpc_pkg::DISPLAY_REQUEST_INPUT_HOLD_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// LED common drive, open drain
	output logic             led_common_drive_o,
	output logic             led_common_drive_oe,
	// Segment sinks shared with program inputs 1 to 5
	input  wire logic [9:0]  segment_sink_outputs_i,
	output logic [4:0]       segment_sink_outputs_o,
	output logic [4:0]       segment_sink_outputs_oe,
	// Program input 6, three level code
	input  wire logic [1:0]  program_select_input6,
	// Display request, three level code
	input  wire logic [1:0]  display_request_input,
	// Measurement inputs
	input  wire logic [15:0] current_sense_input,
	input  wire logic [11:0] battery_voltage_input,
	input  wire logic        charge_complete_input
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Full count from two three level codes
	function automatic logic [23:0] pfc_of(input logic [1:0] a,
	                                       input logic [1:0] b);
		logic [3:0] idx;
		idx = 4'((a * 3) + b + 1);
		return 24'(ldpc_pkg::PFC_STEP * idx);
	endfunction

	// Number of lit segments for a charge against a full reference
	function automatic logic [2:0] seg_level(input logic [23:0] nac,
	                                         input logic [23:0] full);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 1; i <= ldpc_pkg::NUM_SEG; i++) begin
			if (({3'h0, nac} * 27'd5) > ({3'h0, full} * 27'(i - 1)))
				n = 3'(i);
		end
		if (nac == 24'h0)
			n = 3'h0;
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations
	ldpc_pkg::ldpc_state_t state_q;          // Init, sample or run
	logic [31:0]           settle_cnt_q;     // Program settle counter
	logic [9:0]            prog_q;           // Latched codes, pins 1 to 5
	logic [1:0]            prog6_q;          // Latched code, pin 6
	logic                  relative_q;       // Relative display mode
	logic [1:0]            self_dis_q;       // Self discharge rate code
	logic [15:0]           ovld_thr_q;       // Overload threshold
	logic [15:0]           offset_q;         // Offset correction
	logic [1:0]            chg_comp_q;       // Charge compensation shift
	logic [23:0]           pfc_q;            // Programmed full count
	logic [23:0]           nac_q;            // Available charge
	logic [23:0]           lmd_q;            // Learned capacity
	logic                  display_request_input_on_q;        // Display active
	logic [31:0]           display_request_input_cnt_q;       // Push button hold count
	logic [1:0]            display_request_input_prev_q;      // Previous request code
	logic                  ovr_q;            // Host override enable
	logic [5:0]            test_q;           // Commanded pin values
	logic [11:0]           edv_first_q;      // First threshold
	logic [11:0]           edv_final_q;      // Final threshold
	logic                  edv_first_flag_q; // First level reached
	logic                  edv_final_flag_q; // Final level reached
	logic                  ap_wr_q;          // Write pending in data phase
	logic [7:0]            ap_addr_q;        // Latched address
	logic                  ap_take;          // Valid address phase
	logic signed [15:0]    sense;            // Signed sense sample
	logic                  charging;         // Sense above ground
	logic                  overload;         // Discharge above threshold
	logic signed [24:0]    delta;            // Compensated step
	logic signed [25:0]    nac_sum;          // Unsaturated charge
	logic [23:0]           full_ref;         // Display full reference
	logic [2:0]            lit;              // Lit segment count
	logic [31:0]           rd_word;          // Read mux output

	////////////////////////////////////////////////////////////////////////
	// Measurement terms
	assign sense    = signed'(current_sense_input);
	assign charging = sense > 16'sh0000;
	assign overload = (sense < 16'sh0000) &&
	                  (16'(-sense) > ovld_thr_q);
	assign full_ref = relative_q ? lmd_q : pfc_q;
	assign lit      = seg_level(nac_q, full_ref);

	// Compensated step: charge loses a fraction, offset removed
	always_comb begin
		delta = 25'(sense) - 25'(signed'({1'b0, offset_q}));
		if (charging)
			delta = delta - (delta >>> (3'h2 + 3'(chg_comp_q)));
	end
	assign nac_sum = 26'(nac_q) + 26'(delta);

	////////////////////////////////////////////////////////////////////////
	// Start-up sequence: hold drive off, let pins settle, latch codes
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q      <= ldpc_pkg::ST_INIT;
			settle_cnt_q <= 32'h0;
		end else begin
			case (state_q)
				ldpc_pkg::ST_INIT: begin
					state_q      <= ldpc_pkg::ST_SAMPLE;
					settle_cnt_q <= 32'h0;
				end
				ldpc_pkg::ST_SAMPLE: begin
					// Common drive stays off through the whole wait
					settle_cnt_q <= settle_cnt_q + 32'h1;
					if (settle_cnt_q >= SETTLE_CYC - 1)
						state_q <= ldpc_pkg::ST_RUN;
				end
				default: state_q <= ldpc_pkg::ST_RUN;
			endcase
		end
	end

	// Program code latch, taken once at the end of the settle wait
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prog_q     <= 10'h0;
			prog6_q    <= 2'h0;
			relative_q <= 1'b0;
			self_dis_q <= 2'h0;
			ovld_thr_q <= ldpc_pkg::OVLD_LO;
			offset_q   <= 16'h0;
			chg_comp_q <= 2'h0;
			pfc_q      <= ldpc_pkg::PFC_STEP;
		end else if (state_q == ldpc_pkg::ST_SAMPLE &&
		             settle_cnt_q >= SETTLE_CYC - 1) begin
			prog_q     <= segment_sink_outputs_i;
			prog6_q    <= program_select_input6;
			// Pins 1 and 2 pick one of nine full counts
			pfc_q      <= pfc_of(segment_sink_outputs_i[1:0],
			                     segment_sink_outputs_i[3:2]);
			// Pin 3: low is absolute, otherwise relative
			relative_q <= segment_sink_outputs_i[5:4] !=
			              ldpc_pkg::LVL_LOW;
			// Pin 4: self discharge rate and overload level
			self_dis_q <= segment_sink_outputs_i[7:6];
			ovld_thr_q <= (segment_sink_outputs_i[7:6] ==
			               ldpc_pkg::LVL_HIGH) ?
			              ldpc_pkg::OVLD_HI : ldpc_pkg::OVLD_LO;
			// Pin 5: offset correction in counts
			offset_q   <= 16'(segment_sink_outputs_i[9:8]);
			// Pin 6: charge compensation
			chg_comp_q <= program_select_input6;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Charge counter and learned capacity
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			nac_q <= 24'h0;
			lmd_q <= ldpc_pkg::PFC_STEP;
		end else if (state_q == ldpc_pkg::ST_SAMPLE &&
		             settle_cnt_q >= SETTLE_CYC - 1) begin
			// Learned capacity starts at the programmed count
			lmd_q <= pfc_of(segment_sink_outputs_i[1:0],
			                segment_sink_outputs_i[3:2]);
		end else if (ap_wr_q && ap_addr_q == ldpc_pkg::OFS_NAC) begin
			nac_q <= hwdata[23:0];
		end else if (ap_wr_q && ap_addr_q == ldpc_pkg::OFS_LMD) begin
			lmd_q <= hwdata[23:0];
		end else if (state_q == ldpc_pkg::ST_RUN) begin
			// Saturate between empty and the full reference
			if (nac_sum < 26'sh0)
				nac_q <= 24'h0;
			else if (nac_sum > 26'(full_ref))
				nac_q <= full_ref;
			else
				nac_q <= nac_sum[23:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// End of discharge flags, held until the next charge
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			edv_first_flag_q <= 1'b0;
			edv_final_flag_q <= 1'b0;
		end else if (state_q == ldpc_pkg::ST_RUN) begin
			// Detection wins over a clear in the same cycle
			if (!overload && battery_voltage_input < edv_first_q)
				edv_first_flag_q <= 1'b1;
			else if (charging)
				edv_first_flag_q <= 1'b0;
			if (!overload && battery_voltage_input < edv_final_q)
				edv_final_flag_q <= 1'b1;
			else if (charging)
				edv_final_flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Display request handling
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			display_request_input_on_q   <= 1'b0;
			display_request_input_cnt_q  <= 32'h0;
			display_request_input_prev_q <= ldpc_pkg::LVL_HIGH;
		end else begin
			display_request_input_prev_q <= display_request_input;
			if (state_q != ldpc_pkg::ST_RUN) begin
				display_request_input_on_q  <= 1'b0;
				display_request_input_cnt_q <= 32'h0;
			end else if (display_request_input == ldpc_pkg::LVL_HIGH) begin
				display_request_input_on_q  <= 1'b0;
				display_request_input_cnt_q <= 32'h0;
			end else if (display_request_input == ldpc_pkg::LVL_LOW &&
			             display_request_input_prev_q != ldpc_pkg::LVL_LOW) begin
				// Falling request starts a timed display
				display_request_input_on_q  <= 1'b1;
				display_request_input_cnt_q <= DISPLAY_REQUEST_INPUT_HOLD_CYC - 1;
			end else if (display_request_input_cnt_q != 32'h0) begin
				display_request_input_cnt_q <= display_request_input_cnt_q - 32'h1;
			end else if (display_request_input == ldpc_pkg::LVL_FLOAT) begin
				// Open request shows charge while charging or done
				display_request_input_on_q <= charging || charge_complete_input;
			end else begin
				display_request_input_on_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive: override, normal display or released
	always_comb begin
		led_common_drive_o      = 1'b1;
		led_common_drive_oe     = 1'b0;
		segment_sink_outputs_o  = 5'h0;
		segment_sink_outputs_oe = 5'h0;
		if (state_q != ldpc_pkg::ST_RUN) begin
			// Pins read as program inputs
			led_common_drive_oe = 1'b0;
		end else if (ovr_q) begin
			led_common_drive_oe     = test_q[ldpc_pkg::TEST_LED_COMMON_DRIVE_BIT];
			segment_sink_outputs_oe = test_q[4:0];
		end else if (display_request_input_on_q) begin
			led_common_drive_oe = 1'b1;
			// Each lit segment pulls low to sink the LED current
			for (int i = 0; i < ldpc_pkg::NUM_SEG; i++)
				segment_sink_outputs_oe[i] = 3'(i) < lit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ap_take   = hsel && hready && htrans[1];

	// Address phase capture
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ap_wr_q   <= 1'b0;
			ap_addr_q <= 8'h0;
		end else if (hready) begin
			ap_wr_q   <= ap_take && hwrite;
			ap_addr_q <= haddr[7:0];
		end
	end

	// Writable control registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ovr_q       <= 1'b0;
			test_q      <= 6'h0;
			edv_first_q <= ldpc_pkg::EDV_FIRST_RST;
			edv_final_q <= ldpc_pkg::EDV_FINAL_RST;
		end else if (ap_wr_q) begin
			if (ap_addr_q == ldpc_pkg::OFS_CTRL)
				ovr_q <= hwdata[ldpc_pkg::CTRL_OVR_BIT];
			else if (ap_addr_q == ldpc_pkg::OFS_TEST)
				test_q <= hwdata[5:0];
			else if (ap_addr_q == ldpc_pkg::OFS_EDV) begin
				edv_first_q <= hwdata[11:0];
				edv_final_q <= hwdata[ldpc_pkg::EDV_FINAL_LSB +: 12];
			end
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		if (haddr[7:0] == ldpc_pkg::OFS_CTRL)
			rd_word = {31'h0, ovr_q};
		else if (haddr[7:0] == ldpc_pkg::OFS_TEST)
			rd_word = {26'h0, test_q};
		else if (haddr[7:0] == ldpc_pkg::OFS_STATUS)
			rd_word = {20'h0, charge_complete_input, overload,
			           edv_final_flag_q, edv_first_flag_q, charging,
			           lit, display_request_input_on_q, relative_q, 2'(state_q)};
		else if (haddr[7:0] == ldpc_pkg::OFS_PROG)
			rd_word = {18'h0, self_dis_q, prog6_q, prog_q};
		else if (haddr[7:0] == ldpc_pkg::OFS_NAC)
			rd_word = {8'h0, nac_q};
		else if (haddr[7:0] == ldpc_pkg::OFS_LMD)
			rd_word = {8'h0, lmd_q};
		else if (haddr[7:0] == ldpc_pkg::OFS_EDV)
			rd_word = {4'h0, edv_final_q, 4'h0, edv_first_q};
		else
			rd_word = 32'h0;
	end

	// Read data registered at the end of the address phase
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			hrdata <= 32'h0;
		else if (ap_take && !hwrite)
			hrdata <= rd_word;
	end

endmodule

`default_nettype wire

//--- tb/ldpc_checker.sv
// Port assertions for the LED display and program pin block.
// Bound into ldpc_top; a bus snoop follows the host override bit.
`timescale 1ns/1ps
`default_nettype none
module ldpc_checker #(
	parameter int unsigned SETTLE_CYC = ldpc_pkg::SETTLE_CYC
) (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// Pins
	input wire logic        led_common_drive_o,
	input wire logic        led_common_drive_oe,
	input wire logic [4:0]  segment_sink_outputs_o,
	input wire logic [4:0]  segment_sink_outputs_oe,
	input wire logic [1:0]  display_request_input
);
	logic [15:0] up_q;  // Cycles since reset release
	logic        wr_q;  // Control write in data phase
	logic        ovr_q; // Host override seen on bus
	logic        run_w; // Settling surely over
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	assign run_w = up_q > 16'(SETTLE_CYC + 2);
	////////////////////////////////////////////////////////////////////////
	// Count cycles since reset, saturating
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			up_q <= 16'h0;
		end else if (up_q != 16'hFFFF) begin
			up_q <= up_q + 16'h1;
		end
	end
	// Track the override bit from control writes
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wr_q  <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			if (wr_q) begin
				ovr_q <= hwdata[0];
			end
			wr_q <= hsel && hready && htrans[1] && hwrite &&
				haddr[7:0] == ldpc_pkg::OFS_CTRL;
		end
	end
	////////////////////////////////////////////////////////////////////////
	a_init_dark: assert property (
		up_q <= 16'(SETTLE_CYC) |->
		!led_common_drive_oe && segment_sink_outputs_oe == 5'h0)
		else $error("drive on while program pins settle");
	a_req_high_off: assert property (
		display_request_input == ldpc_pkg::LVL_HIGH && !ovr_q |=>
		!led_common_drive_oe)
		else $error("common drive on with request high");
	a_req_high_segs: assert property (
		display_request_input == ldpc_pkg::LVL_HIGH && !ovr_q |=>
		segment_sink_outputs_oe == 5'h0)
		else $error("segment sinking with request high");
	a_fall_lights: assert property (
		run_w && !ovr_q && display_request_input == ldpc_pkg::LVL_LOW &&
		$past(display_request_input) != ldpc_pkg::LVL_LOW |=>
		led_common_drive_oe [*2])
		else $error("falling request did not light display");
	a_seg_needs_com: assert property (
		!ovr_q && segment_sink_outputs_oe != 5'h0 |-> led_common_drive_oe)
		else $error("segment on while common is high impedance");
	a_com_sources: assert property (
		led_common_drive_oe |->
		led_common_drive_o && segment_sink_outputs_o == 5'h0)
		else $error("lamp current path wrong");
	a_bus_okay: assert property (
		hsel && hready && htrans[1] |=> hreadyout && !hresp)
		else $error("bus transfer not ready or not okay");
	a_read_hold: assert property (
		!$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
		else $error("read data moved without a read");
	c_lit: cover property (run_w && led_common_drive_oe);
	c_ovr: cover property (ovr_q && segment_sink_outputs_oe != 5'h0);
	c_rd: cover property (hsel && htrans[1] && !hwrite);
endmodule
bind ldpc_top ldpc_checker #(.SETTLE_CYC(SETTLE_CYC)) ldpc_checker_i (
	.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.led_common_drive_o(led_common_drive_o),
	.led_common_drive_oe(led_common_drive_oe),
	.segment_sink_outputs_o(segment_sink_outputs_o),
	.segment_sink_outputs_oe(segment_sink_outputs_oe),
	.display_request_input(display_request_input));
`default_nettype wire

//--- tb/ldpc_pack_side.sv
// Pack side model: program resistors and LEDs on the shared pins.
// Pins are given as three level codes, two bits a pin.
`timescale 1ns/1ps
`default_nettype none
module ldpc_pack_side (
	// Fitted resistor codes, pins 1 to 6
	input  wire logic [11:0] prog_cfg,
	// Segment sink enables from the block
	input  wire logic [4:0]  seg_oe,
	// Resolved pin codes
	output logic      [9:0]  seg_code,
	output logic      [1:0]  pin6_code
);
	////////////////////////////////////////////////////////////////////////
	// Sinking pin reads low, else the resistor level shows
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			seg_code[2*i +: 2] = seg_oe[i] ? ldpc_pkg::LVL_LOW :
				prog_cfg[2*i +: 2];
		end
	end
	assign pin6_code = prog_cfg[11:10];
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Testbench for ldpc_top: bus tasks, pack model, pin checks.
// Assumes short settle and hold counts set by parameter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int unsigned SETTLE = 4;  // Short settle count
	localparam int unsigned HOLD   = 20; // Short display hold
	logic        sys_clk = 1'b0;  // System clock
	logic        rst_n   = 1'b0;  // Reset, active low
	logic        hsel    = 1'b0;  // Bus select
	logic [31:0] haddr   = 32'h0; // Bus address
	logic [1:0]  htrans  = 2'h0;  // Bus transfer kind
	logic        hwrite  = 1'b0;  // Bus direction
	logic [2:0]  hsize   = 3'h2;  // Bus size
	logic [31:0] hwdata  = 32'h0; // Bus write data
	logic        hreadyout;       // Bus ready
	logic        hresp;           // Bus response
	logic [31:0] hrdata;          // Bus read data
	logic        com_o;           // Common drive level
	logic        com_oe;          // Common drive enable
	logic [9:0]  seg_i;           // Resolved segment pin codes
	logic [4:0]  seg_o;           // Segment drive level
	logic [4:0]  seg_oe;          // Segment sink enables
	logic [1:0]  pin6;            // Program pin 6 code
	logic [1:0]  req = ldpc_pkg::LVL_FLOAT; // Display request
	logic [15:0] sense = 16'h0;   // Sense sample
	logic [11:0] batt = 12'hFFF;  // Battery voltage
	logic        done = 1'b0;     // Charge complete
	logic [11:0] prog_cfg = 12'h800; // Fitted resistors
	logic [31:0] rd;              // Last read data
	logic [31:0] nac0;            // Saved charge
	logic [31:0] pin_w;           // Pin drive summary
	int          fail_count = 0;  // Mismatches
	int          compares = 0;    // Comparisons made
	assign pin_w = {26'h0, com_oe, seg_oe};
	always #4 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////
	ldpc_top #(.SETTLE_CYC(SETTLE), .DISPLAY_REQUEST_INPUT_HOLD_CYC(HOLD)) ldpc_top_i (
		.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .led_common_drive_o(com_o),
		.led_common_drive_oe(com_oe), .segment_sink_outputs_i(seg_i),
		.segment_sink_outputs_o(seg_o), .segment_sink_outputs_oe(seg_oe),
		.program_select_input6(pin6), .display_request_input(req),
		.current_sense_input(sense), .battery_voltage_input(batt),
		.charge_complete_input(done));
	ldpc_pack_side ldpc_pack_side_i (.prog_cfg(prog_cfg), .seg_oe(seg_oe),
		.seg_code(seg_i), .pin6_code(pin6));
	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic stop_test;
		$display("fail_count %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Wait for bus ready under a bound
	task automatic ready_wait;
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			$display("wrong value at %0t: bus hang", $time);
			stop_test();
		end
	endtask
	// One single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		ready_wait();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		ready_wait();
		rd = hrdata;
	endtask
	// Reset with a resistor set fitted
	task automatic do_reset(input logic [11:0] cfg);
		@(posedge sys_clk);
		rst_n    <= 1'b0;
		prog_cfg <= cfg;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
	endtask
	// Drop the request and check pins two cycles on
	task automatic light(input logic [31:0] exp);
		req <= ldpc_pkg::LVL_LOW;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(pin_w, exp);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Bound on the whole run
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		stop_test();
	end
	// Main sequence
	initial begin
		do_reset(12'h800);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(pin_w, 32'h0);
		repeat (SETTLE + 4) @(posedge sys_clk);
		bus(1'b0, ldpc_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h3, 32'h2);
		bus(1'b0, ldpc_pkg::OFS_PROG, 32'h0);
		chk(rd & 32'hFFF, 32'h800);
		prog_cfg <= 12'h6AA;
		bus(1'b0, ldpc_pkg::OFS_PROG, 32'h0);
		chk(rd & 32'hFFF, 32'h800);
		bus(1'b0, ldpc_pkg::OFS_EDV, 32'h0);
		chk(rd, {4'h0, ldpc_pkg::EDV_FINAL_RST, 4'h0,
			ldpc_pkg::EDV_FIRST_RST});
		bus(1'b1, ldpc_pkg::OFS_LMD, 32'h00030000);
		bus(1'b0, ldpc_pkg::OFS_LMD, 32'h0);
		chk(rd, 32'h00030000);
		bus(1'b1, 8'h1C, 32'hFFFFFFFF);
		bus(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		// Absolute mode: three of five lamps
		bus(1'b1, ldpc_pkg::OFS_NAC, 32'h00008000);
		light(32'h27);
		@(posedge sys_clk);
		req <= ldpc_pkg::LVL_HIGH;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(pin_w, 32'h0);
		@(posedge sys_clk);
		req <= ldpc_pkg::LVL_FLOAT;
		repeat (HOLD + 5) @(posedge sys_clk);
		// Host commanded pins
		bus(1'b1, ldpc_pkg::OFS_CTRL, 32'h1);
		bus(1'b1, ldpc_pkg::OFS_TEST, 32'h2A);
		@(negedge sys_clk);
		chk(pin_w, 32'h2A);
		bus(1'b1, ldpc_pkg::OFS_CTRL, 32'h0);
		@(negedge sys_clk);
		chk(pin_w, 32'h0);
		// Charge then discharge
		bus(1'b1, ldpc_pkg::OFS_NAC, 32'h00008000);
		sense <= 16'h0100;
		repeat (40) @(posedge sys_clk);
		sense <= 16'h0;
		@(negedge sys_clk);
		chk({31'h0, com_oe}, 32'h1);
		bus(1'b0, ldpc_pkg::OFS_NAC, 32'h0);
		chk({31'h0, rd > 32'h8000}, 32'h1);
		nac0 = rd;
		sense <= 16'hFF00;
		repeat (40) @(posedge sys_clk);
		sense <= 16'h0;
		bus(1'b0, ldpc_pkg::OFS_NAC, 32'h0);
		chk({31'h0, rd < nac0}, 32'h1);
		// End of discharge levels, then charge clears
		batt <= 12'h3F0;
		repeat (4) @(posedge sys_clk);
		bus(1'b0, ldpc_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h300, 32'h100);
		batt <= 12'h390;
		repeat (4) @(posedge sys_clk);
		bus(1'b0, ldpc_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h300, 32'h300);
		batt  <= 12'hFFF;
		sense <= 16'h0010;
		repeat (4) @(posedge sys_clk);
		sense <= 16'h0;
		bus(1'b0, ldpc_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h300, 32'h0);
		done <= 1'b1;
		repeat (2) @(posedge sys_clk);
		bus(1'b0, ldpc_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h800, 32'h800);
		done <= 1'b0;
		// Heavy discharge: overload holds off end of discharge flags
		sense <= 16'hB000;
		batt  <= 12'h390;
		repeat (4) @(posedge sys_clk);
		bus(1'b0, ldpc_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h700, 32'h400);
		sense <= 16'h0;
		batt  <= 12'hFFF;
		// Relative mode after a second reset: two lamps
		do_reset(12'h810);
		repeat (SETTLE + 4) @(posedge sys_clk);
		bus(1'b1, ldpc_pkg::OFS_LMD, 32'h00020000);
		bus(1'b1, ldpc_pkg::OFS_NAC, 32'h00008000);
		light(32'h23);
		@(posedge sys_clk);
		req <= ldpc_pkg::LVL_FLOAT;
		stop_test();
	end
endmodule
`default_nettype wire
